// File: pmbcf_host_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "pmbcf_map.svh"
module pmbcf_host_model (
   input wire logic clk,
   output logic valid,
   output logic write,
   output logic [7:0] code,
   output logic [15:0] wdata,
   output logic sclk
);
   logic run;
   initial begin
      valid = 1'b0;
      write = 1'b0;
      code = 8'h00;
      wdata = 16'h0000;
      sclk = 1'b0;
      run = 1'b0;
   end
   // ----------------------------------------
   // share clock, still while run is low
   // ----------------------------------------
   always #80 if (run) sclk = ~sclk;
   // ----------------------------------------
   // one command, held for the taking edge
   // ----------------------------------------
   task automatic cmd(input logic w, input logic [7:0] c,
                      input logic [15:0] d);
      @(posedge clk);
      #1;
      valid = 1'b1;
      write = w;
      code = c;
      wdata = d;
      @(posedge clk);
      #1;
      valid = 1'b0;
      // released lines must not keep the last value
      code = ~c;
      wdata = ~d;
   endtask
   task automatic setup();
      cmd(1'b1, `PMBCF_CMD_SETPOINT, 16'h0266);
      cmd(1'b1, `PMBCF_CMD_LOOP, 16'h0001);
   endtask
endmodule
`default_nettype wire

// File: pmbcf_map.svh
`ifndef PMBCF_MAP_SVH
`define PMBCF_MAP_SVH
// ----------------------------------------
// command codes
// ----------------------------------------
`define PMBCF_CMD_OPERATION 8'h01
`define PMBCF_CMD_ON_OFF 8'h02
`define PMBCF_CMD_CLEAR 8'h03
`define PMBCF_CMD_STORE 8'h11
`define PMBCF_CMD_SETPOINT 8'h21
`define PMBCF_CMD_LOOP 8'h29
`define PMBCF_CMD_MISC 8'hF0
// ----------------------------------------
// field positions
// ----------------------------------------
`define PMBCF_OVREL_BIT 0
`define PMBCF_TRIM_LSB 1
`define PMBCF_SHIFT_BIT 4
`define PMBCF_FOUT_BIT 6
`define PMBCF_FIN_BIT 7
`define PMBCF_CLMASK_BIT 8
`define PMBCF_ONOFF_POL_BIT 1
`define PMBCF_ONOFF_CPR_BIT 2
`define PMBCF_ONOFF_CMD_BIT 3
`define PMBCF_OP_ON_BIT 7
// ----------------------------------------
// reset values
// ----------------------------------------
`define PMBCF_MISC_RESET 16'h0193
`define PMBCF_MISC_WMASK 16'h01D7
`define PMBCF_ONOFF_RESET 8'h16
`define PMBCF_OP_RESET 8'h00
`define PMBCF_SETPOINT_RESET 16'h0266
`define PMBCF_LOOP_RESET 16'h0001
// ----------------------------------------
// timing
// ----------------------------------------
`define PMBCF_CLK_NS 5
`define PMBCF_FSW_KHZ 500
`define PMBCF_HALF_CYC (1000000 / (`PMBCF_FSW_KHZ * 2) / `PMBCF_CLK_NS)
`define PMBCF_LOSS_NS 4000
`define PMBCF_LOSS_CYC (`PMBCF_LOSS_NS / `PMBCF_CLK_NS)
`define PMBCF_PG_LO_PCT 95
`define PMBCF_PG_HI_PCT 105
`endif

// File: pmbcf_pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
module pmbcf_pin_sync #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q,
   output logic [W-1:0] rise
);
   typedef struct packed {
      logic [W-1:0] s1_r;
      logic [W-1:0] s2_r;
      logic [W-1:0] s3_r;
   } pmbcf_sync_t;
   pmbcf_sync_t st_r, st_nxt;

   if (W < 1) begin : g_bad_width
      $error("pmbcf_pin_sync: W must be at least 1");
   end

   // ----------------------------------------
   // two-flop synchroniser plus edge stage
   // ----------------------------------------
   always_comb begin
      st_nxt.s1_r = d;
      st_nxt.s2_r = st_r.s1_r;
      st_nxt.s3_r = st_r.s2_r;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign q = st_r.s2_r;
   assign rise = st_r.s2_r & ~st_r.s3_r;
endmodule
`default_nettype wire

// File: pmbcf_pkg.sv
`default_nettype none
package pmbcf_pkg;
   typedef enum logic {PMBCF_LS_IDLE, PMBCF_LS_LATCHED} pmbcf_ls_t;
   typedef logic signed [2:0] pmbcf_trim_t;
   typedef struct packed {
      logic [15:0] misc_r;
      logic [15:0] nv_misc_r;
      logic [15:0] setpoint_r;
      logic [15:0] loop_r;
      logic [7:0] onoff_r;
      logic [7:0] op_r;
      pmbcf_ls_t ls_st;
      logic ls_on;
      logic shift_en;
      logic drv_d;
      logic [9:0] div_cnt;
      logic int_clk;
      logic pwm_clk;
      logic [10:0] loss_cnt;
      logic loss_status;
      logic loss_resp;
      logic share_out;
      logic share_oe;
      logic pg_oe;
      logic conv_en;
      pmbcf_trim_t trim;
      logic rsp_valid;
      logic [15:0] rsp_data;
      logic rsp_err;
   } pmbcf_state_t;
endpackage
`default_nettype wire

// File: pmbcf_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "pmbcf_map.svh"
// Notes on behaviour
// - overvoltage detect latches low-side FET on unless response is ignore
// - release select 0: hold until new startup or clear in disable
// - release select 1: release once feedback falls below 0.2 V
// - trim code 00 none, 01 +12.5%, 10 -25%, 11 -12.5%
// - compensation level shifter enabled only when its bit was high at last capture
// - shifter bit captured at driver enable, frozen while switching
// - export force without import force drives free-running clock onto share pin
// - import force locks switching to clock received on share pin
// - clock-loss mask hides status and suppresses any response
// - power-good pulldown released only inside 95% to 105% window
// - conversion enabled from on/off pin and bus, selectable polarity
// - on/off pin defaults to active high
// - frequency pin low gives default 500 kHz switching
// - store command saves options register to nonvolatile copy
module pmbcf_top #(
   parameter int ALT_HALF_CYC = 100,
   parameter int LOSS_CYC = `PMBCF_LOSS_CYC
) (
   input wire logic CLOCK,
   input wire logic RST,
   input wire logic CMD_VALID,
   input wire logic CMD_WRITE,
   input wire logic [7:0] CMD_CODE,
   input wire logic [15:0] CMD_WDATA,
   output logic RSP_VALID,
   output logic [15:0] RSP_RDATA,
   output logic RSP_ERR,
   input wire logic OV_FAULT_PIN,
   input wire logic OV_RESPONSE_IGNORE,
   input wire logic FEEDBACK_SENSE_LOW,
   input wire logic STARTUP_BEGIN,
   input wire logic DISABLE_STATE,
   input wire logic DRIVER_EN,
   input wire logic ON_OFF_PIN,
   input wire logic FREQUENCY_SELECT_PIN,
   input wire logic SHARE_CLK_IN,
   input wire logic [15:0] VOUT_MEAS,
   output logic SHARE_CLK_OUT,
   output logic SHARE_CLK_OE,
   output logic PWM_CLK,
   output logic LOW_SIDE_ON,
   output pmbcf_pkg::pmbcf_trim_t HS_OC_TRIM,
   output logic COMP_SHIFT_EN,
   output logic CLK_LOSS_STATUS,
   output logic CLK_LOSS_RESP,
   output logic PG_PIN_OUT,
   output logic PG_PIN_OE,
   output logic CONV_ENABLE,
   output logic [15:0] NV_MISC
);
   import pmbcf_pkg::*;

   localparam int HALF_CYC = `PMBCF_HALF_CYC;

   if (ALT_HALF_CYC < 1 || ALT_HALF_CYC > 1023) begin : g_bad_half
      $error("pmbcf_top: ALT_HALF_CYC out of range");
   end
   if (LOSS_CYC < 2 || LOSS_CYC > 2047) begin : g_bad_loss
      $error("pmbcf_top: LOSS_CYC out of range");
   end

   pmbcf_state_t st_r, st_nxt;
   logic [4:0] pin_q, pin_rise;
   logic ov_det, feedback_low, onoff_q, fsel_q, share_q, share_rise;

   pmbcf_pin_sync #(.W(5)) u_sync (
      .clk(CLOCK),
      .rst(RST),
      .d({SHARE_CLK_IN, FREQUENCY_SELECT_PIN, ON_OFF_PIN,
          FEEDBACK_SENSE_LOW, OV_FAULT_PIN}),
      .q(pin_q),
      .rise(pin_rise)
   );
   assign ov_det = pin_q[0];
   assign feedback_low = pin_q[1];
   assign onoff_q = pin_q[2];
   assign fsel_q = pin_q[3];
   assign share_q = pin_q[4];
   assign share_rise = pin_rise[4];

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic pmbcf_trim_t trim_steps(input logic [1:0] code);
      case (code)
         2'h0: trim_steps = 3'sh0;
         2'h1: trim_steps = 3'sh1;
         2'h2: trim_steps = -3'sh2;
         default: trim_steps = -3'sh1;
      endcase
   endfunction

   function automatic logic in_window(input logic [15:0] meas,
                                      input logic [15:0] set);
      logic [23:0] m, lo, hi;
      m = {8'h00, meas} * 24'd100;
      lo = {8'h00, set} * 24'(`PMBCF_PG_LO_PCT);
      hi = {8'h00, set} * 24'(`PMBCF_PG_HI_PCT);
      in_window = (m >= lo) && (m <= hi);
   endfunction

   logic wr, rd, clr_cmd, ov_trip, rel_sel, f_in, f_out, cl_mask;
   logic loss_now, pin_active;
   logic [9:0] half_lim;
   assign wr = CMD_VALID && CMD_WRITE;
   assign rd = CMD_VALID && !CMD_WRITE;
   assign clr_cmd = wr && (CMD_CODE == `PMBCF_CMD_CLEAR);
   assign ov_trip = ov_det && !OV_RESPONSE_IGNORE;
   assign rel_sel = st_r.misc_r[`PMBCF_OVREL_BIT];
   assign f_in = st_r.misc_r[`PMBCF_FIN_BIT];
   assign f_out = st_r.misc_r[`PMBCF_FOUT_BIT];
   assign cl_mask = st_r.misc_r[`PMBCF_CLMASK_BIT];
   assign loss_now = f_in && (st_r.loss_cnt >= 11'(LOSS_CYC));
   assign pin_active = onoff_q ~^ st_r.onoff_r[`PMBCF_ONOFF_POL_BIT];
   assign half_lim = fsel_q ? 10'(ALT_HALF_CYC) : 10'(HALF_CYC);

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      st_nxt = st_r;
      st_nxt.rsp_valid = 1'b0;
      st_nxt.rsp_err = 1'b0;
      if (wr) begin
         case (CMD_CODE)
            `PMBCF_CMD_OPERATION: st_nxt.op_r = CMD_WDATA[7:0];
            `PMBCF_CMD_ON_OFF: st_nxt.onoff_r = CMD_WDATA[7:0];
            `PMBCF_CMD_SETPOINT: st_nxt.setpoint_r = CMD_WDATA;
            `PMBCF_CMD_LOOP: st_nxt.loop_r = CMD_WDATA;
            `PMBCF_CMD_MISC: st_nxt.misc_r =
               (st_r.misc_r & ~`PMBCF_MISC_WMASK) |
               (CMD_WDATA & `PMBCF_MISC_WMASK);
            `PMBCF_CMD_STORE: st_nxt.nv_misc_r = st_r.misc_r;
            `PMBCF_CMD_CLEAR: st_nxt.loss_status = 1'b0;
            default: st_nxt.rsp_err = 1'b1;
         endcase
      end
      if (rd) begin
         st_nxt.rsp_valid = 1'b1;
         case (CMD_CODE)
            `PMBCF_CMD_OPERATION: st_nxt.rsp_data = {8'h00, st_r.op_r};
            `PMBCF_CMD_ON_OFF: st_nxt.rsp_data = {8'h00, st_r.onoff_r};
            `PMBCF_CMD_SETPOINT: st_nxt.rsp_data = st_r.setpoint_r;
            `PMBCF_CMD_LOOP: st_nxt.rsp_data = st_r.loop_r;
            `PMBCF_CMD_MISC: st_nxt.rsp_data = st_r.misc_r;
            default: begin
               st_nxt.rsp_data = 16'h0000;
               st_nxt.rsp_err = 1'b1;
            end
         endcase
      end
      // low-side FET latch
      case (st_r.ls_st)
         PMBCF_LS_IDLE: begin
            if (ov_trip) st_nxt.ls_st = PMBCF_LS_LATCHED;
         end
         PMBCF_LS_LATCHED: begin
            if (ov_trip) begin
               st_nxt.ls_st = PMBCF_LS_LATCHED;
            end else if (!rel_sel &&
                         (STARTUP_BEGIN || (clr_cmd && DISABLE_STATE))) begin
               st_nxt.ls_st = PMBCF_LS_IDLE;
            end else if (rel_sel && feedback_low) begin
               st_nxt.ls_st = PMBCF_LS_IDLE;
            end
         end
         default: st_nxt.ls_st = PMBCF_LS_IDLE;
      endcase
      st_nxt.ls_on = (st_nxt.ls_st == PMBCF_LS_LATCHED);
      st_nxt.trim = trim_steps(st_r.misc_r[`PMBCF_TRIM_LSB +: 2]);
      // shifter enable, captured at driver enable
      st_nxt.drv_d = DRIVER_EN;
      if (!DRIVER_EN || !st_r.drv_d)
         st_nxt.shift_en = st_r.misc_r[`PMBCF_SHIFT_BIT];
      // free-running divider
      if (st_r.div_cnt >= half_lim - 10'h001) begin
         st_nxt.div_cnt = 10'h000;
         st_nxt.int_clk = !st_r.int_clk;
      end else begin
         st_nxt.div_cnt = st_r.div_cnt + 10'h001;
      end
      // clock-loss watchdog on imported clock
      if (!f_in || share_rise)
         st_nxt.loss_cnt = 11'h000;
      else if (!loss_now)
         st_nxt.loss_cnt = st_r.loss_cnt + 11'h001;
      // masked loss neither reported nor acted on
      if (loss_now && !cl_mask)
         st_nxt.loss_status = 1'b1;
      st_nxt.loss_resp = loss_now && !cl_mask;
      // import, fallback to own clock on reported loss
      st_nxt.pwm_clk = (f_in && !(loss_now && !cl_mask)) ?
                       share_q : st_r.int_clk;
      // export, import has priority on the shared pin
      st_nxt.share_oe = f_out && !f_in;
      st_nxt.share_out = st_r.int_clk;
      st_nxt.pg_oe = !in_window(VOUT_MEAS, st_r.setpoint_r);
      st_nxt.conv_en =
         (!st_r.onoff_r[`PMBCF_ONOFF_CMD_BIT] ||
          st_r.op_r[`PMBCF_OP_ON_BIT]) &&
         (!st_r.onoff_r[`PMBCF_ONOFF_CPR_BIT] || pin_active);
   end

   always_ff @(posedge CLOCK) begin
      if (RST) begin
         st_r <= '0;
         st_r.misc_r <= `PMBCF_MISC_RESET;
         st_r.nv_misc_r <= `PMBCF_MISC_RESET;
         st_r.setpoint_r <= `PMBCF_SETPOINT_RESET;
         st_r.loop_r <= `PMBCF_LOOP_RESET;
         st_r.onoff_r <= `PMBCF_ONOFF_RESET;
         st_r.op_r <= `PMBCF_OP_RESET;
         st_r.ls_st <= PMBCF_LS_IDLE;
         st_r.pg_oe <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign RSP_VALID = st_r.rsp_valid;
   assign RSP_RDATA = st_r.rsp_data;
   assign RSP_ERR = st_r.rsp_err;
   assign SHARE_CLK_OUT = st_r.share_out;
   assign SHARE_CLK_OE = st_r.share_oe;
   assign PWM_CLK = st_r.pwm_clk;
   assign LOW_SIDE_ON = st_r.ls_on;
   assign HS_OC_TRIM = st_r.trim;
   assign COMP_SHIFT_EN = st_r.shift_en;
   assign CLK_LOSS_STATUS = st_r.loss_status;
   assign CLK_LOSS_RESP = st_r.loss_resp;
   assign PG_PIN_OUT = 1'b0;
   assign PG_PIN_OE = st_r.pg_oe;
   assign CONV_ENABLE = st_r.conv_en;
   assign NV_MISC = st_r.nv_misc_r;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking @(posedge CLOCK); endclocking
   default disable iff (RST);

   ls_latch_a: assert property (ov_trip |=> LOW_SIDE_ON)
      else $error("low-side FET not latched on overvoltage");
   ls_hold_a: assert property (LOW_SIDE_ON && !rel_sel
      && !STARTUP_BEGIN && !clr_cmd |=> LOW_SIDE_ON)
      else $error("low-side FET released early");
   ls_feedback_a: assert property (LOW_SIDE_ON && rel_sel
      && feedback_low && !ov_trip |=> !LOW_SIDE_ON)
      else $error("low-side FET not released at low feedback");
   trim_map_a: assert property (
      st_r.misc_r[`PMBCF_TRIM_LSB +: 2] == 2'h2 |=> HS_OC_TRIM == -3'sh2)
      else $error("trim code 10 not minus two steps");
   shift_hold_a: assert property (DRIVER_EN && st_r.drv_d
      |=> $stable(COMP_SHIFT_EN))
      else $error("shifter enable changed while switching");
   clk_out_a: assert property (f_out && !f_in |=> SHARE_CLK_OE)
      else $error("clock export not enabled");
   loss_mask_a: assert property ($rose(CLK_LOSS_STATUS)
      |-> !$past(cl_mask))
      else $error("masked clock loss reported");
   pg_win_a: assert property (!in_window(VOUT_MEAS, st_r.setpoint_r)
      |=> PG_PIN_OE)
      else $error("power-good released outside window");
   conv_pin_a: assert property (st_r.onoff_r == `PMBCF_ONOFF_RESET
      && onoff_q ##1 onoff_q |-> CONV_ENABLE)
      else $error("active-high pin did not enable conversion");
   store_a: assert property (wr && CMD_CODE == `PMBCF_CMD_STORE
      |=> NV_MISC == $past(st_r.misc_r))
      else $error("store did not copy options");

   ov_cov: cover property (LOW_SIDE_ON ##[1:50] !LOW_SIDE_ON);
   loss_cov: cover property ($rose(CLK_LOSS_STATUS));
   rd_cov: cover property (rd && CMD_CODE == `PMBCF_CMD_MISC ##1 RSP_VALID);
endmodule
`default_nettype wire

// File: tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "pmbcf_map.svh"
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin fails++; \
   $display("Error t=%0t got %h exp %h", $time, (a), (b)); end end
module tb_top;
   import pmbcf_pkg::*;
   localparam int LOSS = 40;
   typedef struct {
      logic [15:0] wd;
      logic [2:0] trim;
      logic sh;
      logic [15:0] rd;
   } pmbcf_row_t;
   pmbcf_row_t rows[5] = '{'{16'h0000, 3'h0, 1'b0, 16'h0000},
      '{16'h0002, 3'h1, 1'b0, 16'h0002}, '{16'h0004, 3'h6, 1'b0, 16'h0004},
      '{16'h0016, 3'h7, 1'b1, 16'h0016}, '{16'hFFFF, 3'h7, 1'b1, 16'h01D7}};
   logic [15:0] pm[4] = '{16'd583, 16'd584, 16'd644, 16'd645};
   logic pe[4] = '{1'b1, 1'b0, 1'b0, 1'b1};
   int fails = 0;
   int n_checks = 0;
   int n;
   logic CLOCK, RST, CMD_VALID, CMD_WRITE, RSP_VALID, RSP_ERR, ext_clk;
   logic [7:0] CMD_CODE;
   logic [15:0] CMD_WDATA, RSP_RDATA, VOUT_MEAS, NV_MISC;
   logic OV_FAULT_PIN, OV_RESPONSE_IGNORE, FEEDBACK_SENSE_LOW;
   logic STARTUP_BEGIN, DISABLE_STATE, DRIVER_EN, ON_OFF_PIN;
   logic FREQUENCY_SELECT_PIN, SHARE_CLK_IN, SHARE_CLK_OUT, SHARE_CLK_OE;
   logic PWM_CLK, LOW_SIDE_ON, COMP_SHIFT_EN, CLK_LOSS_STATUS;
   logic CLK_LOSS_RESP, PG_PIN_OUT, PG_PIN_OE, CONV_ENABLE;
   pmbcf_trim_t HS_OC_TRIM;
   // share pin level from both drivers
   assign SHARE_CLK_IN = SHARE_CLK_OE ? SHARE_CLK_OUT : ext_clk;
   pmbcf_top #(.ALT_HALF_CYC(50), .LOSS_CYC(LOSS)) dut (.CLOCK, .RST,
      .CMD_VALID, .CMD_WRITE, .CMD_CODE, .CMD_WDATA, .RSP_VALID, .RSP_RDATA,
      .RSP_ERR, .OV_FAULT_PIN, .OV_RESPONSE_IGNORE, .FEEDBACK_SENSE_LOW,
      .STARTUP_BEGIN, .DISABLE_STATE, .DRIVER_EN, .ON_OFF_PIN,
      .FREQUENCY_SELECT_PIN, .SHARE_CLK_IN, .VOUT_MEAS, .SHARE_CLK_OUT,
      .SHARE_CLK_OE, .PWM_CLK, .LOW_SIDE_ON, .HS_OC_TRIM, .COMP_SHIFT_EN,
      .CLK_LOSS_STATUS, .CLK_LOSS_RESP, .PG_PIN_OUT, .PG_PIN_OE,
      .CONV_ENABLE, .NV_MISC);
   pmbcf_host_model host (.clk(CLOCK), .valid(CMD_VALID), .write(CMD_WRITE),
      .code(CMD_CODE), .wdata(CMD_WDATA), .sclk(ext_clk));
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic stop_test();
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic tick(input int k);
      repeat (k) @(posedge CLOCK);
      #1;
   endtask
   task automatic wr(input logic [7:0] c, input logic [15:0] d);
      host.cmd(1'b1, c, d);
      tick(2);
   endtask
   task automatic rd(input logic [7:0] c, input logic [15:0] exp);
      host.cmd(1'b0, c, 16'h0000);
      `CHK(RSP_VALID, 1'b1);
      `CHK(RSP_RDATA, exp);
   endtask
   task automatic wait_ext(input logic v);
      int k;
      for (k = 0; k < 40 && ext_clk !== v; k++) tick(1);
      if (k == 40) begin
         fails++;
         stop_test();
      end
   endtask
   // cycles between two changes of the exported clock
   task automatic gap(output int g);
      logic v;
      for (int i = 0; i < 2; i++) begin
         v = SHARE_CLK_OUT;
         g = 0;
         while (SHARE_CLK_OUT === v && g < 1000) begin
            tick(1);
            g++;
         end
      end
      if (g >= 1000) begin
         fails++;
         stop_test();
      end
   endtask
   initial begin
      CLOCK = 1'b0;
      forever #2.5 CLOCK = ~CLOCK;
   end
   initial begin
      #400000;
      fails++;
      stop_test();
   end
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      RST = 1'b1;
      {OV_FAULT_PIN, OV_RESPONSE_IGNORE, FEEDBACK_SENSE_LOW} = 3'h0;
      {STARTUP_BEGIN, DISABLE_STATE, DRIVER_EN, ON_OFF_PIN} = 4'h0;
      FREQUENCY_SELECT_PIN = 1'b0;
      VOUT_MEAS = 16'h0000;
      tick(2);
      RST = 1'b0;
      tick(3);
      `CHK(NV_MISC, `PMBCF_MISC_RESET);
      `CHK(CONV_ENABLE, 1'b0);
      rd(`PMBCF_CMD_MISC, `PMBCF_MISC_RESET);
      rd(`PMBCF_CMD_ON_OFF, 16'h0016);
      wr(`PMBCF_CMD_SETPOINT, 16'h0200);
      rd(`PMBCF_CMD_SETPOINT, 16'h0200);
      host.setup();
      rd(`PMBCF_CMD_SETPOINT, 16'h0266);
      rd(`PMBCF_CMD_LOOP, 16'h0001);
      foreach (rows[i]) begin
         wr(`PMBCF_CMD_MISC, rows[i].wd);
         `CHK(HS_OC_TRIM, rows[i].trim);
         `CHK(COMP_SHIFT_EN, rows[i].sh);
         rd(`PMBCF_CMD_MISC, rows[i].rd);
      end
      host.cmd(1'b0, 8'h55, 16'h0000);
      `CHK(RSP_ERR, 1'b1);
      wr(`PMBCF_CMD_MISC, 16'h0010);
      DRIVER_EN = 1'b1;
      tick(2);
      wr(`PMBCF_CMD_MISC, 16'h0000);
      `CHK(COMP_SHIFT_EN, 1'b1);
      DRIVER_EN = 1'b0;
      tick(2);
      `CHK(COMP_SHIFT_EN, 1'b0);
      {OV_RESPONSE_IGNORE, OV_FAULT_PIN} = 2'h3;
      tick(4);
      `CHK(LOW_SIDE_ON, 1'b0);
      OV_RESPONSE_IGNORE = 1'b0;
      tick(2);
      `CHK(LOW_SIDE_ON, 1'b1);
      {OV_FAULT_PIN, FEEDBACK_SENSE_LOW} = 2'h1;
      tick(4);
      wr(`PMBCF_CMD_CLEAR, 16'h0000);
      `CHK(LOW_SIDE_ON, 1'b1);
      DISABLE_STATE = 1'b1;
      wr(`PMBCF_CMD_CLEAR, 16'h0000);
      `CHK(LOW_SIDE_ON, 1'b0);
      {DISABLE_STATE, OV_FAULT_PIN} = 2'h1;
      tick(4);
      OV_FAULT_PIN = 1'b0;
      tick(4);
      `CHK(LOW_SIDE_ON, 1'b1);
      STARTUP_BEGIN = 1'b1;
      tick(1);
      STARTUP_BEGIN = 1'b0;
      tick(1);
      `CHK(LOW_SIDE_ON, 1'b0);
      FEEDBACK_SENSE_LOW = 1'b0;
      wr(`PMBCF_CMD_MISC, 16'h0001);
      OV_FAULT_PIN = 1'b1;
      tick(4);
      OV_FAULT_PIN = 1'b0;
      tick(4);
      `CHK(LOW_SIDE_ON, 1'b1);
      FEEDBACK_SENSE_LOW = 1'b1;
      tick(4);
      `CHK(LOW_SIDE_ON, 1'b0);
      FEEDBACK_SENSE_LOW = 1'b0;
      wr(`PMBCF_CMD_MISC, 16'h0040);
      `CHK(SHARE_CLK_OE, 1'b1);
      gap(n);
      `CHK(n, `PMBCF_HALF_CYC);
      FREQUENCY_SELECT_PIN = 1'b1;
      tick(4);
      gap(n);
      `CHK(n, 50);
      FREQUENCY_SELECT_PIN = 1'b0;
      host.run = 1'b1;
      wr(`PMBCF_CMD_MISC, 16'h0080);
      wr(`PMBCF_CMD_CLEAR, 16'h0000);
      tick(LOSS);
      `CHK(SHARE_CLK_OE, 1'b0);
      `CHK(CLK_LOSS_STATUS, 1'b0);
      wait_ext(1'b0);
      wait_ext(1'b1);
      tick(8);
      `CHK(PWM_CLK, 1'b1);
      tick(16);
      `CHK(PWM_CLK, 1'b0);
      host.run = 1'b0;
      tick(LOSS + 10);
      `CHK(CLK_LOSS_STATUS, 1'b1);
      `CHK(CLK_LOSS_RESP, 1'b1);
      host.run = 1'b1;
      tick(40);
      wr(`PMBCF_CMD_CLEAR, 16'h0000);
      `CHK(CLK_LOSS_STATUS, 1'b0);
      wr(`PMBCF_CMD_MISC, 16'h0180);
      host.run = 1'b0;
      tick(LOSS + 10);
      `CHK(CLK_LOSS_STATUS, 1'b0);
      `CHK(CLK_LOSS_RESP, 1'b0);
      foreach (pm[i]) begin
         VOUT_MEAS = pm[i];
         tick(2);
         `CHK(PG_PIN_OE, pe[i]);
      end
      `CHK(PG_PIN_OUT, 1'b0);
      ON_OFF_PIN = 1'b1;
      tick(4);
      `CHK(CONV_ENABLE, 1'b1);
      wr(`PMBCF_CMD_ON_OFF, 16'h0014);
      `CHK(CONV_ENABLE, 1'b0);
      ON_OFF_PIN = 1'b0;
      tick(4);
      `CHK(CONV_ENABLE, 1'b1);
      wr(`PMBCF_CMD_ON_OFF, 16'h001C);
      `CHK(CONV_ENABLE, 1'b0);
      wr(`PMBCF_CMD_OPERATION, 16'h0080);
      `CHK(CONV_ENABLE, 1'b1);
      rd(`PMBCF_CMD_OPERATION, 16'h0080);
      wr(`PMBCF_CMD_MISC, 16'h0102);
      wr(`PMBCF_CMD_STORE, 16'h0000);
      `CHK(NV_MISC, 16'h0102);
      RST = 1'b1;
      tick(2);
      RST = 1'b0;
      tick(3);
      rd(`PMBCF_CMD_MISC, `PMBCF_MISC_RESET);
      stop_test();
   end
endmodule
`default_nettype wire
